//--- rbm_pkg.sv
/*
 Shared constants and types for the reset, boot-mode and memory-map block.
 Assumes a 32-bit processor address bus and a 50 MHz master clock.
*/
package rbm_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int FETCH_HOLD_CYCLES = 80;
    localparam int STRAP_WINDOW_CYCLES = 10;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] FETCH_HOLD_CNT = 8'(FETCH_HOLD_CYCLES);
    localparam logic [CNT_W-1:0] STRAP_WINDOW_CNT = 8'(STRAP_WINDOW_CYCLES);

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam logic [31:0] EXT_LOW = 32'h0040_0000;
    localparam logic [31:0] EXT_HIGH = 32'hFFC0_0000;
    localparam logic [31:0] SRAM_BYTES = 32'h0000_2000;
    localparam logic [31:0] VECTOR_TOP = 32'h0000_0020;
    localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
    localparam int SRAM_AW = 11;
    localparam int NUM_CS = 8;
    localparam logic [7:0] REMAP_BIT = 8'h00;

    // ------------------------------------------------------------
    // Bank layouts and shared types
    // ------------------------------------------------------------
    localparam int BANK_SEL_W = 2;
    localparam int WAIT_W = 3;
    localparam int FLOAT_W = 3;

    typedef enum logic [1:0] {
        RBM_REG_INT = 2'b00,
        RBM_REG_EXT = 2'b01,
        RBM_REG_PERIPH = 2'b10
    } rbm_region_t;

    typedef enum logic [1:0] {
        RBM_RST_HOLD = 2'b00,
        RBM_RST_WAIT = 2'b01,
        RBM_RST_RUN = 2'b10
    } rbm_rst_state_t;

    typedef enum logic [1:0] {
        RBM_SZ_BYTE = 2'b00,
        RBM_SZ_HALF = 2'b01,
        RBM_SZ_WORD = 2'b10
    } rbm_size_t;

    typedef enum logic {
        RBM_BW_16 = 1'b0,
        RBM_BW_8 = 1'b1
    } rbm_width_t;

    // Per-bank configuration: bank select is the size code, 1M..16M
    typedef struct packed {
        logic [31:0] base;
        logic [BANK_SEL_W-1:0] size_code;
        logic [WAIT_W-1:0] wait_states;
        logic [FLOAT_W-1:0] float_time;
        rbm_width_t width;
        logic byte_write;
        logic enable;
    } rbm_bank_t;
endpackage

//--- rbm_bus_if.sv
/*
 Processor-side access bundle shared between the top and its decoder.
 Assumes a single-clock system; no timing is carried by the interface.
*/
`timescale 1ns/100ps
interface rbm_bus_if;
    import rbm_pkg::*;
    logic valid;
    logic write;
    logic [31:0] addr;
    rbm_size_t size;
    logic remapped;
    rbm_width_t boot_width;
    rbm_region_t region;
    logic [rbm_pkg::NUM_CS-1:0] cs_hit;
    logic sram_sel;
    logic boot_sel;
    logic abort;
    logic aligned;
    logic [3:0] lanes;

    modport ctrl (output valid, write, addr, size, remapped, boot_width,
                  input region, cs_hit, sram_sel, boot_sel, abort, aligned, lanes);
    modport dec (input valid, write, addr, size, remapped, boot_width,
                 output region, cs_hit, sram_sel, boot_sel, abort, aligned, lanes);
endinterface

//--- rbm_decoder.sv
/*
 Combinational address decoder: region split, remap, chip-select hit and abort.
 Assumes bank configuration is stable while an access is presented.
*/
`timescale 1ns/100ps
module rbm_decoder (
    rbm_bus_if.dec bus,
    input wire rbm_pkg::rbm_bank_t banks_i [rbm_pkg::NUM_CS]
);
    import rbm_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] bank_span(input logic [BANK_SEL_W-1:0] code);
        case (code)
            2'h0: bank_span = 32'h0010_0000;
            2'h1: bank_span = 32'h0040_0000;
            2'h2: bank_span = 32'h0080_0000;
            default: bank_span = 32'h0100_0000;
        endcase
    endfunction

    wire is_int = bus.addr < EXT_LOW;
    wire is_periph = bus.addr >= EXT_HIGH;
    wire low_vec = bus.addr < SRAM_BYTES;
    wire [NUM_CS-1:0] hit;

    // ------------------------------------------------------------
    // Chip-select windows
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_CS; g++) begin : g_cs
            wire [31:0] top = banks_i[g].base + bank_span(banks_i[g].size_code);
            assign hit[g] = banks_i[g].enable && !is_int && !is_periph &&
                            bus.addr >= banks_i[g].base && bus.addr < top;
        end
    endgenerate

    wire boot_zone = is_int && !bus.remapped;
    wire sram_zone = is_int && bus.remapped && low_vec;

    assign bus.region = is_int ? RBM_REG_INT : (is_periph ? RBM_REG_PERIPH : RBM_REG_EXT);
    assign bus.sram_sel = bus.valid && sram_zone;
    assign bus.boot_sel = bus.valid && boot_zone;
    assign bus.cs_hit = bus.valid ? (hit | {{(NUM_CS-1){1'b0}}, boot_zone}) : '0;
    // Undefined external addresses abort; internal and peripheral space never does
    assign bus.abort = bus.valid && !is_int && !is_periph && (hit == '0);
    assign bus.aligned = (bus.size == RBM_SZ_BYTE) ||
                         (bus.size == RBM_SZ_HALF && !bus.addr[0]) ||
                         (bus.size == RBM_SZ_WORD && bus.addr[1:0] == 2'b00);
    // Little-endian lane select in every region
    assign bus.lanes = (bus.size == RBM_SZ_WORD) ? 4'hF :
                       (bus.size == RBM_SZ_HALF) ? (bus.addr[1] ? 4'hC : 4'h3) :
                       4'(4'h1 << bus.addr[1:0]);
endmodule

//--- rbm_sram.sv
/*
 Internal SRAM, 32 bits wide, single-cycle byte, half-word and word access.
 Assumes lane enables are already little-endian decoded.
*/
`timescale 1ns/100ps
module rbm_sram #(
    parameter int AW = rbm_pkg::SRAM_AW
) (
    input wire logic mclk_i,
    input wire logic ce_i,
    input wire logic sel_i,
    input wire logic write_i,
    input wire logic [AW-1:0] word_i,
    input wire logic [3:0] lanes_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Contents are left undefined at reset, as memory is not a register
    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_lane
            // One array per lane keeps each storage cell under a single writer
            logic [7:0] lane_mem [2**AW];
            always_ff @(posedge mclk_i) begin
                if (ce_i && sel_i && write_i && lanes_i[b]) begin
                    lane_mem[word_i] <= wdata_i[8*b +: 8];
                end
            end
            assign rdata_o[8*b +: 8] = lane_mem[word_i];
        end
    endgenerate
endmodule

//--- rbm_top.sv
/*
 Reset sequencer, strap capture, remap state and memory-map front end.
 Assumes the processor presents one access per cycle while fetch is enabled.
*/
// Behaviour
// - Low reset pin enters reset at once; release is clock-synchronised.
// - First fetch waits eighty cycles after reset pin rises.
// - Any reset restores peripheral defaults and fetch from address zero.
// - Clock output low in reset, then copies master clock until reassigned.
// - Watchdog reset acts as pin reset but keeps captured boot modes.
// - Simultaneous pin and watchdog reset counts as pin reset.
// - Tri-state select low for last ten cycles disables all drivers.
// - Boot width sampled last ten cycles: one 8-bit, zero 16-bit.
// - After reset every peripheral pin is an input.
// - Address space splits into internal, external and peripheral regions.
// - External interface serves addresses 0x0040_0000 up to 0xFFC0_0000.
// - Little-endian byte order everywhere.
// - 8K SRAM, 32 bits wide, every access size in one cycle.
// - After remap, SRAM sits at zero so vectors are writable.
// - Writing one to the remap bit switches zero to SRAM.
// - Remap persists until a reset; writing zero does nothing.
// - Undefined external addresses raise abort.
// - Internal memory and peripheral accesses never abort.
// - Banks range from eight 1-Mbyte to four 16-Mbyte.
// - Each bank has wait states, float time, width and write style.
`timescale 1ns/100ps
module rbm_top #(
    parameter int NUM_PIO = 32
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic reset_in_n_i,
    input wire logic wdog_reset_i,
    input wire logic boot_width_select_i,
    input wire logic tristate_select_n_i,
    input wire logic clk_out_as_pio_i,
    input wire logic remap_wr_i,
    input wire logic [7:0] remap_control_reg_i,
    input wire rbm_pkg::rbm_bank_t banks_i [rbm_pkg::NUM_CS],
    input wire logic acc_valid_i,
    input wire logic acc_write_i,
    input wire logic [31:0] acc_addr_i,
    input wire rbm_pkg::rbm_size_t acc_size_i,
    input wire logic [31:0] acc_wdata_i,
    output logic core_reset_o,
    output logic fetch_enable_o,
    output logic [31:0] fetch_addr_o,
    output logic periph_reset_o,
    output logic master_clk_out_o,
    output logic tristate_mode_o,
    output logic drivers_en_o,
    output rbm_pkg::rbm_width_t boot_width_o,
    output logic [NUM_PIO-1:0] pio_oe_o,
    output logic remapped_o,
    output logic abort_o,
    output logic [31:0] sram_rdata_o,
    output rbm_pkg::rbm_region_t region_o,
    output logic [rbm_pkg::NUM_CS-1:0] cs_sel_o,
    output logic [rbm_pkg::WAIT_W-1:0] ext_wait_o,
    output logic [rbm_pkg::FLOAT_W-1:0] ext_float_o,
    output logic ext_width8_o,
    output logic ext_byte_write_o,
    output logic [3:0] lanes_o,
    output logic chip_select0_n_o
);
    import rbm_pkg::*;

    // ------------------------------------------------------------
    // Reset pin: asserted without the clock, released through two flops
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_sync_n;
    always_ff @(posedge mclk_i or negedge reset_in_n_i) begin
        if (!reset_in_n_i) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end
    wire pin_reset = !rst_sync_n || rst_i;

    // Strap pins come from outside; two flops before any use
    logic bw_m;
    logic bw_s;
    logic ts_m;
    logic ts_s;
    logic wd_m;
    logic wd_s;
    always_ff @(posedge mclk_i) begin
        bw_m <= boot_width_select_i;
        bw_s <= bw_m;
        ts_m <= tristate_select_n_i;
        ts_s <= ts_m;
        wd_m <= wdog_reset_i;
        wd_s <= wd_m;
    end

    // Pin reset takes priority over the watchdog when both are present
    wire wd_reset = wd_s && !pin_reset;
    wire any_reset = pin_reset || wd_reset;

    // ------------------------------------------------------------
    // Strap window: only the last ten cycles before release count
    // ------------------------------------------------------------
    // The release point is only known when it arrives, so a running
    // window of the last samples is kept instead of a start trigger.
    logic [STRAP_WINDOW_CYCLES-1:0] bw_hist;
    logic [STRAP_WINDOW_CYCLES-1:0] ts_hist;
    logic pin_reset_d;
    always_ff @(posedge mclk_i) begin
        if (ce_i) begin
            bw_hist <= {bw_hist[STRAP_WINDOW_CYCLES-2:0], bw_s};
            ts_hist <= {ts_hist[STRAP_WINDOW_CYCLES-2:0], ts_s};
            pin_reset_d <= pin_reset;
        end
    end
    wire pin_release = pin_reset_d && !pin_reset;
    wire ts_all_low = (ts_hist == '0);
    // Boot width taken as the majority-free last sample of the window
    wire bw_value = bw_hist[0];

    // Modes captured only on pin release; the watchdog never touches them
    always_ff @(posedge mclk_i) begin
        if (ce_i && pin_release) begin
            tristate_mode_o <= ts_all_low;
            boot_width_o <= bw_value ? RBM_BW_8 : RBM_BW_16;
        end
    end

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    rbm_rst_state_t state;
    rbm_rst_state_t next_state;
    logic [CNT_W-1:0] hold_cnt;
    logic [CNT_W-1:0] next_hold_cnt;

    always_comb begin
        next_state = state;
        next_hold_cnt = hold_cnt;
        case (state)
            RBM_RST_HOLD: begin
                next_hold_cnt = 8'h01;
                if (!any_reset) begin
                    next_state = RBM_RST_WAIT;
                end
            end
            RBM_RST_WAIT: begin
                next_hold_cnt = hold_cnt + 8'h01;
                if (hold_cnt == FETCH_HOLD_CNT - 8'h01) begin
                    next_state = RBM_RST_RUN;
                end
            end
            RBM_RST_RUN: begin
                next_hold_cnt = hold_cnt;
            end
            default: begin
                next_state = RBM_RST_HOLD;
            end
        endcase
        if (any_reset) begin
            next_state = RBM_RST_HOLD;
            next_hold_cnt = 8'h00;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (any_reset) begin
            state <= RBM_RST_HOLD;
            hold_cnt <= 8'h00;
        end else if (ce_i) begin
            state <= next_state;
            hold_cnt <= next_hold_cnt;
        end
    end

    // ------------------------------------------------------------
    // Remap: sticky until any reset, writing zero is ignored
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (any_reset) begin
            remapped_o <= 1'b0;
        end else if (ce_i && remap_wr_i && remap_control_reg_i[REMAP_BIT[2:0]]) begin
            remapped_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Decoder and SRAM
    // ------------------------------------------------------------
    rbm_bus_if bus ();
    assign bus.valid = acc_valid_i && (state == RBM_RST_RUN);
    assign bus.write = acc_write_i;
    assign bus.addr = acc_addr_i;
    assign bus.size = acc_size_i;
    assign bus.remapped = remapped_o;
    assign bus.boot_width = boot_width_o;

    rbm_decoder u_dec (
        .bus(bus.dec),
        .banks_i(banks_i)
    );

    wire [31:0] sram_rd;
    rbm_sram #(
        .AW(SRAM_AW)
    ) u_sram (
        .mclk_i(mclk_i),
        .ce_i(ce_i),
        .sel_i(bus.sram_sel),
        .write_i(acc_write_i),
        .word_i(acc_addr_i[SRAM_AW+1:2]),
        .lanes_i(bus.lanes),
        .wdata_i(acc_wdata_i),
        .rdata_o(sram_rd)
    );

    // First hit bank steers the external timing fields
    function automatic logic [2:0] first_hit(input logic [NUM_CS-1:0] v);
        first_hit = 3'h0;
        for (int i = NUM_CS - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_hit = 3'(i);
            end
        end
    endfunction
    wire [2:0] bank_idx = first_hit(bus.cs_hit);
    wire boot_bank = bus.boot_sel;
    wire sel_width8 = boot_bank ? (boot_width_o == RBM_BW_8) : (banks_i[bank_idx].width == RBM_BW_8);

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (any_reset) begin
            core_reset_o <= 1'b1;
            fetch_enable_o <= 1'b0;
            fetch_addr_o <= RESET_VECTOR;
            periph_reset_o <= 1'b1;
            pio_oe_o <= '0;
            abort_o <= 1'b0;
            sram_rdata_o <= 32'h0000_0000;
            region_o <= RBM_REG_INT;
            cs_sel_o <= '0;
            ext_wait_o <= '0;
            ext_float_o <= '0;
            ext_width8_o <= 1'b0;
            ext_byte_write_o <= 1'b0;
            lanes_o <= 4'h0;
            chip_select0_n_o <= 1'b1;
            drivers_en_o <= 1'b0;
        end else if (ce_i) begin
            core_reset_o <= 1'b0;
            fetch_enable_o <= (state == RBM_RST_RUN);
            fetch_addr_o <= RESET_VECTOR;
            periph_reset_o <= 1'b0;
            pio_oe_o <= '0;
            abort_o <= bus.abort;
            sram_rdata_o <= sram_rd;
            region_o <= bus.region;
            cs_sel_o <= tristate_mode_o ? '0 : bus.cs_hit;
            ext_wait_o <= banks_i[bank_idx].wait_states;
            ext_float_o <= banks_i[bank_idx].float_time;
            ext_width8_o <= sel_width8;
            ext_byte_write_o <= !sel_width8 && banks_i[bank_idx].byte_write;
            lanes_o <= bus.lanes;
            chip_select0_n_o <= !(bus.cs_hit[0] && !tristate_mode_o);
            drivers_en_o <= !tristate_mode_o;
        end
    end

    // Clock copy: gated low in reset; a flop-fed enable keeps the gate glitch-free
    logic clk_out_en;
    always_ff @(negedge mclk_i) begin
        if (any_reset) begin
            clk_out_en <= 1'b0;
        end else begin
            clk_out_en <= !clk_out_as_pio_i && !tristate_mode_o;
        end
    end
    always_comb begin
        master_clk_out_o = mclk_i && clk_out_en && !pin_reset;
    end
endmodule

//--- rbm_top_sva.sv
/*
 Checker for the reset, strap and memory-map block, bound to rbm_top.
 Assumes one clock domain and sees only the top module's ports.
*/
`timescale 1ns/100ps
module rbm_top_sva #(
    parameter int NUM_PIO = 32
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic reset_in_n_i,
    input wire logic wdog_reset_i,
    input wire logic remap_wr_i,
    input wire logic [7:0] remap_control_reg_i,
    input wire logic acc_valid_i,
    input wire logic acc_write_i,
    input wire logic [31:0] acc_addr_i,
    input wire logic core_reset_o,
    input wire logic fetch_enable_o,
    input wire logic [31:0] fetch_addr_o,
    input wire logic periph_reset_o,
    input wire logic master_clk_out_o,
    input wire logic tristate_mode_o,
    input wire logic drivers_en_o,
    input wire rbm_pkg::rbm_width_t boot_width_o,
    input wire logic [NUM_PIO-1:0] pio_oe_o,
    input wire logic remapped_o,
    input wire logic abort_o,
    input wire rbm_pkg::rbm_region_t region_o,
    input wire logic [rbm_pkg::NUM_CS-1:0] cs_sel_o
);
    import rbm_pkg::*;
    // ------------------------------------------------------------
    // Cycles since pin release, saturating so later resets pass
    // ------------------------------------------------------------
    logic [7:0] rise_cnt;
    always_ff @(posedge mclk_i) begin
        if (!reset_in_n_i) begin
            rise_cnt <= 8'h00;
        end else if (rise_cnt != 8'hFF) begin
            rise_cnt <= rise_cnt + 8'h01;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_pin_reset_now: assert property (!reset_in_n_i |=> core_reset_o && periph_reset_o)
        else $error("pin reset not taken");
    a_fetch_hold: assert property ($rose(fetch_enable_o) |-> rise_cnt >= 8'h4F)
        else $error("fetch too early");
    a_reset_quiet: assert property (core_reset_o |-> !fetch_enable_o && !abort_o && cs_sel_o == '0)
        else $error("activity in reset");
    a_fetch_zero: assert property (fetch_enable_o |-> fetch_addr_o == RESET_VECTOR)
        else $error("fetch address not zero");
    a_clk_out_low: assert property (@(negedge mclk_i) core_reset_o |-> !master_clk_out_o)
        else $error("clock output in reset");
    a_wdog_keeps_straps: assert property (wdog_reset_i && reset_in_n_i && $past(reset_in_n_i, 4)
        |=> $stable(boot_width_o) && $stable(tristate_mode_o)) else $error("straps changed");
    a_drivers_follow: assert property (fetch_enable_o |-> drivers_en_o == !tristate_mode_o)
        else $error("driver enable wrong");
    a_pio_inputs: assert property (fetch_enable_o |-> pio_oe_o == '0)
        else $error("pin driven");
    a_ext_region: assert property (acc_valid_i && fetch_enable_o && acc_addr_i >= EXT_LOW
        && acc_addr_i < EXT_HIGH |=> region_o == RBM_REG_EXT) else $error("external miss");
    a_no_int_abort: assert property (acc_valid_i && fetch_enable_o && (acc_addr_i >= EXT_HIGH
        || (acc_addr_i < EXT_LOW && !acc_write_i)) |=> !abort_o) else $error("internal abort");
    a_remap_set: assert property (remap_wr_i && remap_control_reg_i[0] && fetch_enable_o |=> remapped_o)
        else $error("remap ignored");
    a_remap_sticky: assert property (remapped_o && !core_reset_o |=> remapped_o || core_reset_o)
        else $error("remap undone");
endmodule

//--- rbm_core_model.sv
/*
 Processor core model issuing one access at a time to the block.
 Assumes the bench calls access from procedural code; drives on the falling edge.
*/
`timescale 1ns/100ps
module rbm_core_model (
    input wire logic mclk_i,
    input wire logic fetch_enable_i,
    output logic acc_valid_o,
    output logic acc_write_o,
    output logic [31:0] acc_addr_o,
    output rbm_pkg::rbm_size_t acc_size_o,
    output logic [31:0] acc_wdata_o
);
    import rbm_pkg::*;
    initial begin
        acc_valid_o = 1'b0;
        acc_write_o = 1'b0;
        acc_addr_o = 32'h0;
        acc_size_o = RBM_SZ_WORD;
        acc_wdata_o = 32'h0;
    end
    task automatic access(input logic w, input logic [31:0] a, input rbm_size_t s, input logic [31:0] d);
        @(negedge mclk_i);
        while (fetch_enable_i !== 1'b1) begin
            @(negedge mclk_i);
        end
        acc_valid_o = 1'b1;
        acc_write_o = w;
        acc_addr_o = a;
        acc_size_o = s;
        acc_wdata_o = d;
        @(negedge mclk_i);
        // Released write, address and data lines carry inverted values so stale data cannot match; size keeps its value
        acc_valid_o = 1'b0;
        acc_write_o = ~w;
        acc_addr_o = ~a;
        acc_wdata_o = ~d;
    endtask
endmodule

//--- tb.sv
/*
 Self-checking bench for rbm_top: resets, straps, remap and address decode.
 Assumes the core model in rbm_core_model.sv and the checker in rbm_top_sva.sv.
*/
`timescale 1ns/100ps
module tb;
    import rbm_pkg::*;
    localparam int NUM_PIO = 32;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic reset_in_n_i = 1'b0;
    logic wdog_reset_i = 1'b0;
    logic boot_width_select_i = 1'b1;
    logic tristate_select_n_i = 1'b0;
    logic clk_out_as_pio_i = 1'b0;
    logic remap_wr_i = 1'b0;
    logic [7:0] remap_control_reg_i = 8'h00;
    rbm_bank_t banks_i [NUM_CS];
    logic acc_valid_i, acc_write_i;
    logic [31:0] acc_addr_i, acc_wdata_i, fetch_addr_o, sram_rdata_o;
    rbm_size_t acc_size_i;
    logic core_reset_o, fetch_enable_o, periph_reset_o, master_clk_out_o, tristate_mode_o, drivers_en_o;
    logic remapped_o, abort_o, ext_width8_o, ext_byte_write_o, chip_select0_n_o;
    rbm_width_t boot_width_o;
    logic [NUM_PIO-1:0] pio_oe_o;
    rbm_region_t region_o;
    logic [NUM_CS-1:0] cs_sel_o;
    logic [WAIT_W-1:0] ext_wait_o;
    logic [FLOAT_W-1:0] ext_float_o;
    logic [3:0] lanes_o;
    int failures = 0;
    int n_checks = 0;
    always #10 mclk_i = ~mclk_i;
    rbm_top #(.NUM_PIO(NUM_PIO)) dut (.*);
    rbm_core_model core (.mclk_i, .fetch_enable_i(fetch_enable_o), .acc_valid_o(acc_valid_i),
        .acc_write_o(acc_write_i), .acc_addr_o(acc_addr_i), .acc_size_o(acc_size_i), .acc_wdata_o(acc_wdata_i));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (failures == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic remap_write(input logic [7:0] v);
        @(negedge mclk_i);
        remap_wr_i = 1'b1;
        remap_control_reg_i = v;
        @(negedge mclk_i);
        remap_wr_i = 1'b0;
        remap_control_reg_i = ~v;
    endtask
    task automatic wait_fetch(output int n);
        n = 0;
        while (fetch_enable_o !== 1'b1 && n < 300) begin
            @(negedge mclk_i);
            n++;
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Pin reset with straps; glitch lifts tristate select once inside the window
    task automatic t_pin_reset(input logic tri_n, input logic bw, input logic wd, input logic glitch);
        int n;
        @(negedge mclk_i);
        boot_width_select_i = bw;
        tristate_select_n_i = tri_n;
        wdog_reset_i = wd;
        reset_in_n_i = 1'b0;
        @(posedge mclk_i);
        #1 chk(core_reset_o, 1);
        for (int i = 0; i < 15; i++) begin
            @(posedge mclk_i);
            #5 chk(master_clk_out_o, 0);
            @(negedge mclk_i);
            tristate_select_n_i = tri_n | (glitch && i == 10);
            if (i == 8) begin
                wdog_reset_i = 1'b0;
            end
        end
        reset_in_n_i = 1'b1;
        wait_fetch(n);
        chk(n >= 80 && n <= 86, 1);
        chk(tristate_mode_o, !tri_n && !glitch);
        chk(drivers_en_o, tri_n || glitch);
        chk(boot_width_o, bw);
        chk(remapped_o, 0);
        chk(fetch_addr_o, RESET_VECTOR);
        chk(pio_oe_o, 0);
    endtask
    task automatic t_map();
        logic [31:0] ta [6] = '{32'h003F_FFFC, 32'h0040_0000, 32'h0100_0010, 32'h0300_0000, 32'hFFBF_FFFC,
            32'hFFC0_0000};
        logic [31:0] te [6] = '{32'h000, 32'h202, 32'h204, 32'h201, 32'h201, 32'h400};
        core.access(0, 32'h0, RBM_SZ_WORD, 32'h0);
        chk({cs_sel_o, chip_select0_n_o}, 9'h002);
        remap_write(8'h00);
        chk(remapped_o, 0);
        remap_write(8'h01);
        chk(remapped_o, 1);
        remap_write(8'hFE);
        chk(remapped_o, 1);
        core.access(1, 32'h8, RBM_SZ_WORD, 32'h1122_3344);
        core.access(1, 32'h9, RBM_SZ_BYTE, 32'hAAAA_AAAA);
        chk(lanes_o, 4'h2);
        core.access(1, 32'hA, RBM_SZ_HALF, 32'h5566_5566);
        chk(lanes_o, 4'hC);
        core.access(0, 32'h8, RBM_SZ_WORD, 32'h0);
        chk(sram_rdata_o, 32'h5566_AA44);
        chk({abort_o, cs_sel_o}, 9'h000);
        for (int i = 0; i < 6; i++) begin
            core.access(0, ta[i], RBM_SZ_WORD, 32'h0);
            chk({region_o, cs_sel_o, abort_o}, te[i]);
        end
        core.access(1, 32'h0100_0012, RBM_SZ_BYTE, 32'h7777_7777);
        chk({ext_wait_o, ext_float_o, ext_width8_o, lanes_o}, {3'h5, 3'h2, 1'b1, 4'h4});
    endtask
    // Watchdog reset with new strap levels that must not be taken
    task automatic t_wdog();
        int n;
        @(negedge mclk_i);
        tristate_select_n_i = 1'b0;
        boot_width_select_i = 1'b1;
        wdog_reset_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        chk(core_reset_o, 1);
        repeat (4) @(negedge mclk_i);
        wdog_reset_i = 1'b0;
        wait_fetch(n);
        chk({tristate_mode_o, boot_width_o, remapped_o}, {1'b0, RBM_BW_16, 1'b0});
    endtask
    task automatic t_clkout();
        @(posedge mclk_i);
        #5 chk(master_clk_out_o, 1);
        @(negedge mclk_i);
        clk_out_as_pio_i = 1'b1;
        #5 chk(master_clk_out_o, 0);
        repeat (2) @(posedge mclk_i);
        #5 chk(master_clk_out_o, 0);
    endtask
    initial begin
        banks_i = '{default: '0};
        banks_i[0].size_code = 2'h3;
        banks_i[0].enable = 1'b1;
        banks_i[1].base = 32'h0100_0000;
        banks_i[1].wait_states = 3'h5;
        banks_i[1].float_time = 3'h2;
        banks_i[1].width = RBM_BW_8;
        banks_i[1].enable = 1'b1;
        repeat (16) @(negedge mclk_i);
        rst_i = 1'b0;
        t_pin_reset(1'b0, 1'b1, 1'b0, 1'b0);
        t_pin_reset(1'b0, 1'b0, 1'b0, 1'b1);
        t_map();
        t_wdog();
        t_pin_reset(1'b1, 1'b1, 1'b1, 1'b0);
        t_clkout();
        end_of_test();
    end
    initial begin
        #50us;
        failures++;
        end_of_test();
    end
endmodule
bind rbm_top rbm_top_sva #(.NUM_PIO(NUM_PIO)) u_sva (.mclk_i, .rst_i, .reset_in_n_i, .wdog_reset_i, .remap_wr_i,
    .remap_control_reg_i, .acc_valid_i, .acc_write_i, .acc_addr_i, .core_reset_o, .fetch_enable_o, .fetch_addr_o,
    .periph_reset_o, .master_clk_out_o, .tristate_mode_o, .drivers_en_o, .boot_width_o, .pio_oe_o, .remapped_o,
    .abort_o, .region_o, .cs_sel_o);
